// >>> hw/orla_regs.svh
// Register offsets, field positions, OTP map and timing counts for the OTP access block
`ifndef ORLA_REGS_SVH
`define ORLA_REGS_SVH
// ----------------------------------------
// APB register offsets
// ----------------------------------------
`define ORLA_REG_CTRL 12'h000
`define ORLA_REG_STATUS 12'h004
`define ORLA_REG_ESN_LOCK 12'h008
`define ORLA_REG_REGION_LOCK 12'h00C
`define ORLA_REG_EVENT 12'h010
`define ORLA_CTRL_RST 32'h0000_0001
`define ORLA_CTRL_OTP_EN_BIT 0
`define ORLA_ST_WEL_BIT 0
`define ORLA_ST_OTP_SPACE_BIT 1
`define ORLA_ST_PROG_BUSY_BIT 2
`define ORLA_ST_ACCEL_BLOCK_BIT 3
`define ORLA_EV_REFUSED_BIT 0
`define ORLA_EV_DONE_BIT 1
// ----------------------------------------
// Serial opcodes
// ----------------------------------------
`define ORLA_OPC_WRITE_ENABLE_CMD 8'h06
`define ORLA_OPC_OTP_PROGRAM_CMD 8'h42
`define ORLA_OPC_OTP_READ_CMD 8'h4B
// ----------------------------------------
// OTP address map
// ----------------------------------------
`define ORLA_P1_LO 24'h00_0100
`define ORLA_P1_HI 24'h00_0111
`define ORLA_LOWER_SERIAL_REGION_LO 24'h00_0102
`define ORLA_LOWER_SERIAL_REGION_HI 24'h00_0109
`define ORLA_UPPER_SERIAL_REGION_LO 24'h00_010A
`define ORLA_P2_LO 24'h00_0212
`define ORLA_P2_HI 24'h00_03FF
`define ORLA_REGION_LO 24'h00_0216
`define ORLA_P2_IDX_BASE 24'h00_0012
`define ORLA_IDX_ESN_LOCK 9'h000
`define ORLA_IDX_LOCK_B0 9'h012
`define ORLA_IDX_LOCK_B3 9'h015
`define ORLA_ESN_LOCK_KEEP 8'hFC
`define ORLA_LAST_LOCK_KEEP 8'h80
`define ORLA_ERASED_BYTE 8'hFF
`define ORLA_LOWER_SERIAL_REGION_LOCKED 8'hFE
`define ORLA_BOTH_ESN_LOCKED 8'hFC
// ----------------------------------------
// Timing
// ----------------------------------------
`define ORLA_CLK_PERIOD_NS 32'h0000_0064
`define ORLA_PROG_TIME_NS 32'h0000_03E8
`define ORLA_PROG_CYCLES (`ORLA_PROG_TIME_NS / `ORLA_CLK_PERIOD_NS)
`endif

// >>> hw/orla_pkg.sv
// Types shared by the OTP access block
`default_nettype none
package orla_pkg;
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic accel_hv;
  } orla_pins_t;

  typedef enum logic [2:0] {
    ORLA_OPCODE,
    ORLA_ADDR,
    ORLA_DUMMY,
    ORLA_RD_DATA,
    ORLA_WR_DATA,
    ORLA_SKIP
  } orla_state_t;
endpackage : orla_pkg
`default_nettype wire

// >>> hw/orla_store.sv
// Flip-flop storage of the OTP bytes with their delivery contents
`include "orla_regs.svh"
`default_nettype none
module orla_store #(
  parameter logic [63:0] LOWER_SERIAL_REGION_VALUE = 64'h5A3C_9E17_C04B_D268,
  parameter logic CUSTOMER_UPPER_SERIAL_REGION = 1'b0,
  parameter logic [63:0] UPPER_SERIAL_REGION_VALUE = 64'hFFFF_FFFF_FFFF_FFFF
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic factory_init_in,
  // Write port
  input wire logic wr_en_in,
  input wire logic [8:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  // Read port and lock bytes
  input wire logic [8:0] rd_idx_in,
  output logic [7:0] rd_data_out,
  output logic [7:0] esn_lock_out,
  output logic [31:0] region_lock_out
);
  logic [7:0] mem_ff [0:511];

  // Contents are nonvolatile: no reset, only a factory load
  genvar gi;
  generate
    for (gi = 0; gi < 512; gi = gi + 1)
    begin : g_byte
      // Shifts are clamped so unused branches never select outside the pattern
      localparam int LOWER_SERIAL_REGION_SH = (gi >= 2 && gi < 10) ? 8 * (9 - gi) : 0;
      localparam int UPPER_SERIAL_REGION_SH = (gi >= 10 && gi < 18) ? 8 * (17 - gi) : 0;
      localparam logic [7:0] INIT_VAL =
        (gi == 0) ? (CUSTOMER_UPPER_SERIAL_REGION ? `ORLA_BOTH_ESN_LOCKED : `ORLA_LOWER_SERIAL_REGION_LOCKED) :
        (gi >= 2 && gi < 10) ? 8'(LOWER_SERIAL_REGION_VALUE >> LOWER_SERIAL_REGION_SH) :
        (gi >= 10 && gi < 18 && CUSTOMER_UPPER_SERIAL_REGION) ? 8'(UPPER_SERIAL_REGION_VALUE >> UPPER_SERIAL_REGION_SH) :
        `ORLA_ERASED_BYTE;
      always_ff @(posedge clk_in)
      begin
        if (en_in)
        begin
          if (factory_init_in)
            mem_ff[gi] <= INIT_VAL;
          else if (wr_en_in && wr_idx_in == 9'(gi))
            mem_ff[gi] <= wr_data_in;
        end
      end
    end
  endgenerate

  assign rd_data_out = mem_ff[rd_idx_in];
  assign esn_lock_out = mem_ff[0];
  assign region_lock_out = {mem_ff[21], mem_ff[20], mem_ff[19], mem_ff[18]};
endmodule : orla_store
`default_nettype wire

// >>> hw/orla_top.sv
// OTP region access, locking and serial command handling
`include "orla_regs.svh"
`default_nettype none
module orla_top #(
  parameter logic [63:0] LOWER_SERIAL_REGION_VALUE = 64'h5A3C_9E17_C04B_D268,
  parameter logic CUSTOMER_UPPER_SERIAL_REGION = 1'b0
) (
  // Clock, reset, enable
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  input wire logic FACTORY_INIT_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Serial pins
  input wire orla_pkg::orla_pins_t PINS_IN,
  output logic SO_OUT,
  output logic SO_OE_N_OUT,
  // Device context
  input wire logic EMBEDDED_BUSY_IN,
  input wire logic QUAD_MODE_IN,
  // Status
  output logic WEL_OUT,
  output logic OTP_SPACE_OUT,
  output logic PROG_BUSY_OUT
);
  import orla_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  orla_pins_t s1_ff, s2_ff, s3_ff, pin_ff, prev_ff;

  // A change counts only once the second and third stage agree
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      s1_ff <= 4'hC;
      s2_ff <= 4'hC;
      s3_ff <= 4'hC;
      pin_ff <= 4'hC;
      prev_ff <= 4'hC;
    end
    else if (CLK_EN_IN)
    begin
      s1_ff <= PINS_IN;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      prev_ff <= pin_ff;
      for (int b = 0; b < 4; b++)
      begin
        if (s2_ff[b] == s3_ff[b])
          pin_ff[b] <= s3_ff[b];
      end
    end
  end

  logic sck_rise, sck_fall, cs_rise, cs_fall;
  assign sck_rise = pin_ff.sck && !prev_ff.sck && !pin_ff.cs_n;
  assign sck_fall = !pin_ff.sck && prev_ff.sck && !pin_ff.cs_n;
  assign cs_rise = pin_ff.cs_n && !prev_ff.cs_n;
  assign cs_fall = !pin_ff.cs_n && prev_ff.cs_n;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  orla_state_t state_ff;
  logic [7:0] shift_ff, data_ff, out_sh_ff;
  logic [2:0] bit_cnt_ff, out_cnt_ff;
  logic [1:0] addr_cnt_ff, data_cnt_ff;
  logic [23:0] addr_ff;
  logic is_read_ff, wel_ff, otp_space_ff, so_ff, so_oe_n_ff;
  logic [7:0] prog_cnt_ff;
  logic [31:0] ctrl_ff, prdata_ff;
  logic ev_refused_ff, ev_done_ff;

  logic [7:0] in_byte, rd_data, rd_byte, esn_lock, keep_mask;
  logic [31:0] region_lock;
  logic byte_done, accel_block, prog_busy, access_ok;
  logic p1_hit, p2_hit, cur_locked, prog_go, prog_refuse, cmd_refuse;
  logic [8:0] cur_idx;
  logic [23:0] reg_off;
  logic [4:0] reg_num;

  assign in_byte = {shift_ff[6:0], pin_ff.si};
  assign byte_done = sck_rise && bit_cnt_ff == 3'h7;
  assign prog_busy = prog_cnt_ff != 8'h00;
  assign accel_block = pin_ff.accel_hv && !QUAD_MODE_IN;
  assign access_ok = ctrl_ff[`ORLA_CTRL_OTP_EN_BIT] && !EMBEDDED_BUSY_IN
    && !accel_block && !prog_busy;

  // ----------------------------------------
  // OTP address decode
  // ----------------------------------------
  always_comb
  begin
    p1_hit = addr_ff >= `ORLA_P1_LO && addr_ff <= `ORLA_P1_HI;
    p2_hit = addr_ff >= `ORLA_P2_LO && addr_ff <= `ORLA_P2_HI;
    reg_off = addr_ff - `ORLA_REGION_LO;
    reg_num = reg_off[8:4]; // 10-byte region lands on number 30
    if (p1_hit)
      cur_idx = 9'(addr_ff - `ORLA_P1_LO);
    else
      cur_idx = 9'(addr_ff - `ORLA_P2_LO + `ORLA_P2_IDX_BASE);
    // Lock bits are active low: a programmed zero locks
    if (addr_ff >= `ORLA_LOWER_SERIAL_REGION_LO && addr_ff <= `ORLA_LOWER_SERIAL_REGION_HI)
      cur_locked = !esn_lock[0];
    else if (addr_ff >= `ORLA_UPPER_SERIAL_REGION_LO && p1_hit)
      cur_locked = !esn_lock[1];
    else if (addr_ff >= `ORLA_REGION_LO && p2_hit)
      cur_locked = !region_lock[reg_num];
    else
      cur_locked = 1'b0;
    if (cur_idx == `ORLA_IDX_ESN_LOCK)
      keep_mask = `ORLA_ESN_LOCK_KEEP;
    else if (cur_idx == `ORLA_IDX_LOCK_B3)
      keep_mask = `ORLA_LAST_LOCK_KEEP;
    else
      keep_mask = 8'h00;
  end

  // Beyond the last address the read returns erased fill, never wraps
  assign rd_byte = (p1_hit || p2_hit) ? rd_data : `ORLA_ERASED_BYTE;

  assign prog_go = cs_rise && state_ff == ORLA_WR_DATA && data_cnt_ff == 2'h1
    && wel_ff && (p1_hit || p2_hit) && !cur_locked;
  assign prog_refuse = cs_rise && state_ff == ORLA_WR_DATA && !prog_go;
  assign cmd_refuse = byte_done && state_ff == ORLA_OPCODE && !access_ok
    && (in_byte == `ORLA_OPC_OTP_PROGRAM_CMD || in_byte == `ORLA_OPC_OTP_READ_CMD);

  orla_store #(
    .LOWER_SERIAL_REGION_VALUE(LOWER_SERIAL_REGION_VALUE),
    .CUSTOMER_UPPER_SERIAL_REGION(CUSTOMER_UPPER_SERIAL_REGION),
    .UPPER_SERIAL_REGION_VALUE(64'hFFFF_FFFF_FFFF_FFFF)
  ) u_store (
    .clk_in(CLK_IN),
    .en_in(CLK_EN_IN),
    .factory_init_in(FACTORY_INIT_IN),
    .wr_en_in(prog_go),
    .wr_idx_in(cur_idx),
    .wr_data_in(rd_data & (data_ff | keep_mask)),
    .rd_idx_in(cur_idx),
    .rd_data_out(rd_data),
    .esn_lock_out(esn_lock),
    .region_lock_out(region_lock)
  );

  // ----------------------------------------
  // Serial command sequencer
  // ----------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      state_ff <= ORLA_OPCODE;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      addr_cnt_ff <= 2'h0;
      addr_ff <= 24'h00_0000;
      is_read_ff <= 1'b0;
      data_ff <= 8'hFF;
      data_cnt_ff <= 2'h0;
    end
    else if (CLK_EN_IN)
    begin
      if (cs_fall || cs_rise)
      begin
        state_ff <= ORLA_OPCODE;
        bit_cnt_ff <= 3'h0;
        addr_cnt_ff <= 2'h0;
        data_cnt_ff <= 2'h0;
      end
      else if (sck_rise)
      begin
        shift_ff <= in_byte;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (byte_done)
        begin
          unique case (state_ff)
            ORLA_OPCODE:
            begin
              if ((in_byte == `ORLA_OPC_OTP_PROGRAM_CMD || in_byte == `ORLA_OPC_OTP_READ_CMD) && access_ok)
              begin
                state_ff <= ORLA_ADDR;
                is_read_ff <= in_byte == `ORLA_OPC_OTP_READ_CMD;
              end
              else
                state_ff <= ORLA_SKIP;
            end
            ORLA_ADDR:
            begin
              addr_ff <= {addr_ff[15:0], in_byte};
              addr_cnt_ff <= addr_cnt_ff + 2'h1;
              if (addr_cnt_ff == 2'h2)
                state_ff <= is_read_ff ? ORLA_DUMMY : ORLA_WR_DATA;
            end
            ORLA_DUMMY:
              state_ff <= ORLA_RD_DATA;
            ORLA_WR_DATA:
            begin
              data_ff <= in_byte;
              if (data_cnt_ff != 2'h2)
                data_cnt_ff <= data_cnt_ff + 2'h1;
            end
            ORLA_RD_DATA, ORLA_SKIP:
              state_ff <= state_ff;
          endcase
        end
      end
      else if (sck_fall && state_ff == ORLA_RD_DATA && out_cnt_ff == 3'h0)
        addr_ff <= addr_ff + 24'h00_0001;
    end
  end

  // ----------------------------------------
  // Read data shifter
  // ----------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      out_sh_ff <= 8'h00;
      out_cnt_ff <= 3'h0;
      so_ff <= 1'b0;
      so_oe_n_ff <= 1'b1;
    end
    else if (CLK_EN_IN)
    begin
      so_oe_n_ff <= !(state_ff == ORLA_RD_DATA && !pin_ff.cs_n);
      if (state_ff != ORLA_RD_DATA)
        out_cnt_ff <= 3'h0;
      else if (sck_fall)
      begin
        out_cnt_ff <= out_cnt_ff + 3'h1;
        if (out_cnt_ff == 3'h0)
        begin
          so_ff <= rd_byte[7];
          out_sh_ff <= {rd_byte[6:0], 1'b0};
        end
        else
        begin
          so_ff <= out_sh_ff[7];
          out_sh_ff <= {out_sh_ff[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // Write-enable latch, OTP space, program timer
  // ----------------------------------------
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      wel_ff <= 1'b0;
    else if (CLK_EN_IN)
    begin
      if (byte_done && state_ff == ORLA_OPCODE && in_byte == `ORLA_OPC_WRITE_ENABLE_CMD && !accel_block)
        wel_ff <= 1'b1;
      else if (prog_go)
        wel_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      otp_space_ff <= 1'b0;
    else if (CLK_EN_IN)
    begin
      if (cs_rise || cs_fall)
        otp_space_ff <= 1'b0;
      else if (byte_done && state_ff == ORLA_OPCODE && access_ok
               && (in_byte == `ORLA_OPC_OTP_PROGRAM_CMD || in_byte == `ORLA_OPC_OTP_READ_CMD))
        otp_space_ff <= 1'b1;
    end
  end

  // Fixed program time: the accel pin never shortens it
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      prog_cnt_ff <= 8'h00;
    else if (CLK_EN_IN)
    begin
      if (prog_go)
        prog_cnt_ff <= 8'(`ORLA_PROG_CYCLES);
      else if (prog_busy)
        prog_cnt_ff <= prog_cnt_ff - 8'h01;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic apb_wr, apb_known;
  logic [31:0] rd_mux;
  assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && CLK_EN_IN;
  assign apb_known = PADDR_IN == `ORLA_REG_CTRL || PADDR_IN == `ORLA_REG_STATUS
    || PADDR_IN == `ORLA_REG_ESN_LOCK || PADDR_IN == `ORLA_REG_REGION_LOCK
    || PADDR_IN == `ORLA_REG_EVENT;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (PADDR_IN)
      `ORLA_REG_CTRL: rd_mux = ctrl_ff;
      `ORLA_REG_STATUS:
      begin
        rd_mux[`ORLA_ST_WEL_BIT] = wel_ff;
        rd_mux[`ORLA_ST_OTP_SPACE_BIT] = otp_space_ff;
        rd_mux[`ORLA_ST_PROG_BUSY_BIT] = prog_busy;
        rd_mux[`ORLA_ST_ACCEL_BLOCK_BIT] = accel_block;
      end
      `ORLA_REG_ESN_LOCK: rd_mux = {24'h00_0000, esn_lock};
      `ORLA_REG_REGION_LOCK: rd_mux = region_lock;
      `ORLA_REG_EVENT:
      begin
        rd_mux[`ORLA_EV_REFUSED_BIT] = ev_refused_ff;
        rd_mux[`ORLA_EV_DONE_BIT] = ev_done_ff;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      prdata_ff <= 32'h0000_0000;
    else if (CLK_EN_IN && PSEL_IN && !PENABLE_IN)
      prdata_ff <= rd_mux;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
      ctrl_ff <= `ORLA_CTRL_RST;
    else if (apb_wr && PADDR_IN == `ORLA_REG_CTRL)
      ctrl_ff <= {31'h0000_0000, PWDATA_IN[`ORLA_CTRL_OTP_EN_BIT]};
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN)
    begin
      ev_refused_ff <= 1'b0;
      ev_done_ff <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      if (cmd_refuse || prog_refuse)
        ev_refused_ff <= 1'b1;
      else if (apb_wr && PADDR_IN == `ORLA_REG_EVENT && PWDATA_IN[`ORLA_EV_REFUSED_BIT])
        ev_refused_ff <= 1'b0;
      if (prog_go)
        ev_done_ff <= 1'b1;
      else if (apb_wr && PADDR_IN == `ORLA_REG_EVENT && PWDATA_IN[`ORLA_EV_DONE_BIT])
        ev_done_ff <= 1'b0;
    end
  end

  assign PRDATA_OUT = prdata_ff;
  assign PREADY_OUT = PSEL_IN && PENABLE_IN && CLK_EN_IN;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && CLK_EN_IN && !apb_known;
  assign SO_OUT = so_ff;
  assign SO_OE_N_OUT = so_oe_n_ff;
  assign WEL_OUT = wel_ff;
  assign OTP_SPACE_OUT = otp_space_ff;
  assign PROG_BUSY_OUT = prog_busy;
endmodule : orla_top
`default_nettype wire

// >>> verification/orla_checker.sv
// Port checker for the OTP access block
`default_nettype none
module orla_checker (
  // Clock, reset and APB
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic CLK_EN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // Serial pins and device context
  input wire orla_pkg::orla_pins_t PINS_IN,
  input wire logic SO_OE_N_OUT,
  input wire logic EMBEDDED_BUSY_IN,
  input wire logic QUAD_MODE_IN,
  // Status
  input wire logic WEL_OUT,
  input wire logic OTP_SPACE_OUT,
  input wire logic PROG_BUSY_OUT
);
  import orla_pkg::*;
  logic [3:0] busy_len_ff;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  // Saturates so a stuck busy flag cannot wrap back to a legal count
  always_ff @(posedge CLK_IN)
  begin
    if (RESET_IN || !PROG_BUSY_OUT)
      busy_len_ff <= 4'h0;
    else if (CLK_EN_IN && busy_len_ff != 4'hF)
      busy_len_ff <= busy_len_ff + 4'h1;
  end
  a_pready_access: assert property (PREADY_OUT == (PSEL_IN && PENABLE_IN && CLK_EN_IN))
    else $error("pready not tied to access phase");
  a_slverr_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("slave error outside access phase");
  a_reset_standby: assert property ($fell(RESET_IN) |-> !WEL_OUT && !OTP_SPACE_OUT && !PROG_BUSY_OUT)
    else $error("state not cleared by reset");
  a_prog_length: assert property ($fell(PROG_BUSY_OUT) |-> busy_len_ff == 4'd10)
    else $error("program pulse length wrong");
  a_prog_drops_wel: assert property ($rose(PROG_BUSY_OUT) |-> ##[0:1] !WEL_OUT)
    else $error("write enable kept after program");
  a_wel_clear_cause: assert property ($fell(WEL_OUT) |-> ##[0:1] PROG_BUSY_OUT)
    else $error("write enable lost without program");
  a_busy_refuse: assert property ($rose(OTP_SPACE_OUT) |-> !$past(EMBEDDED_BUSY_IN))
    else $error("otp entered during embedded operation");
  a_accel_refuse: assert property ($rose(OTP_SPACE_OUT) |-> !($past(PINS_IN.accel_hv, 8) && !QUAD_MODE_IN))
    else $error("otp entered with accel voltage");
  a_space_ends: assert property (PINS_IN.cs_n [*6] |-> !OTP_SPACE_OUT)
    else $error("otp space kept after deselect");
  a_so_released: assert property (PINS_IN.cs_n [*6] |-> SO_OE_N_OUT)
    else $error("serial out driven while deselected");
  c_program: cover property ($rose(PROG_BUSY_OUT));
  c_read_out: cover property ($fell(SO_OE_N_OUT));
  c_slverr: cover property (PSLVERR_OUT);
endmodule : orla_checker
bind orla_top orla_checker i_orla_checker (.*);
`default_nettype wire

// >>> verification/orla_host_model.sv
// Behavioural host serial controller for the OTP access block
`default_nettype none
module orla_host_model (
  // Clock and device data
  input wire logic clk_in,
  input wire logic so_in,
  // Pins towards the device
  output var orla_pkg::orla_pins_t pins_out
);
  import orla_pkg::*;
  // Device needs two cycles per level and about five cycles after a clock fall before read data shows
  localparam int HALF = 8;
  initial pins_out = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, accel_hv: 1'b0};
  task automatic step(input logic s, input logic d);
    @(posedge clk_in);
    pins_out.sck <= s;
    pins_out.si <= d;
    repeat (HALF - 1) @(posedge clk_in);
  endtask : step
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      step(1'b0, b[i]);
      step(1'b1, b[i]);
    end
  endtask : send_byte
  task automatic start_cmd(input logic [7:0] opc, input logic [23:0] a, input logic with_addr);
    @(posedge clk_in);
    pins_out.cs_n <= 1'b0;
    send_byte(opc);
    if (with_addr)
    begin
      send_byte(a[23:16]);
      send_byte(a[15:8]);
      send_byte(a[7:0]);
    end
  endtask : start_cmd
  task automatic end_cmd();
    step(1'b0, 1'b0);
    @(posedge clk_in);
    pins_out.cs_n <= 1'b1;
    pins_out.si <= ~pins_out.si;
    repeat (2 * HALF) @(posedge clk_in);
  endtask : end_cmd
  task automatic cmd_write_enable_cmd();
    start_cmd(8'h06, 24'h00_0000, 1'b0);
    end_cmd();
  endtask : cmd_write_enable_cmd
  task automatic cmd_prog(input logic [23:0] a, input logic [7:0] d, input int n);
    start_cmd(8'h42, a, 1'b1);
    repeat (n) send_byte(d);
    end_cmd();
  endtask : cmd_prog
  task automatic cmd_read(input logic [23:0] a, output logic [15:0] q);
    start_cmd(8'h4B, a, 1'b1);
    send_byte(8'h00);
    for (int i = 0; i < 16; i++)
    begin
      step(1'b0, i[0]);
      @(negedge clk_in);
      q = {q[14:0], so_in};
      step(1'b1, ~i[0]);
    end
    end_cmd();
  endtask : cmd_read
  task automatic set_accel(input logic v);
    @(posedge clk_in);
    pins_out.accel_hv <= v;
    repeat (50) @(posedge clk_in);
  endtask : set_accel
endmodule : orla_host_model
`default_nettype wire

// >>> verification/orla_top_tb.sv
// Self-checking bench for the OTP access block
`include "orla_regs.svh"
`default_nettype none
module orla_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import orla_pkg::*;
  logic clk, rst, clk_en, finit, psel, penable, pwrite, pready, pslverr, so, so_oe_n, emb, quad, write_enable_latch, space, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] sd;
  logic [23:0] base;
  logic [7:0] d1, d2;
  logic err;
  orla_pins_t pins;
  int mismatches, tests_run;
  orla_top i_orla_top (.CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(clk_en), .FACTORY_INIT_IN(finit),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PINS_IN(pins), .SO_OUT(so),
    .SO_OE_N_OUT(so_oe_n), .EMBEDDED_BUSY_IN(emb), .QUAD_MODE_IN(quad), .WEL_OUT(write_enable_latch),
    .OTP_SPACE_OUT(space), .PROG_BUSY_OUT(busy));
  orla_host_model i_orla_host_model (.clk_in(clk), .so_in(so), .pins_out(pins));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : next_rand
  function automatic logic [7:0] prog_result(input logic [7:0] old, input logic [7:0] d, input logic [7:0] keep);
    return old & (d | keep);
  endfunction : prog_result
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial
  begin
    {rst, clk_en, finit} = 3'b111;
    {psel, penable, pwrite, emb, quad} = 5'b0_0000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    seed = next_rand(32'h5c3c_6c7b);
    base = `ORLA_REGION_LO + 24'(seed % 24) * 24'h00_0010;
    d1 = seed[15:8];
    d2 = seed[23:16];
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    finit <= 1'b0;
    repeat (10) @(posedge clk);
    apb(1'b0, `ORLA_REG_CTRL, 32'h0); check(rd, 32'h0000_0001);
    apb(1'b0, `ORLA_REG_STATUS, 32'h0); check(rd, 32'h0000_0000);
    apb(1'b0, `ORLA_REG_ESN_LOCK, 32'h0); check(rd, 32'h0000_00FE);
    apb(1'b0, `ORLA_REG_REGION_LOCK, 32'h0); check(rd, 32'hFFFF_FFFF);
    apb(1'b0, 12'h014, 32'h0); check({err, rd}, {1'b1, 32'h0});
    i_orla_host_model.cmd_read(24'h00_03FE, sd); check(sd, 16'hFFFF);
    i_orla_host_model.cmd_prog(base + 24'h1, 8'h00, 1);
    i_orla_host_model.cmd_write_enable_cmd();
    check(write_enable_latch, 1'b1);
    i_orla_host_model.cmd_prog(base, d1, 1);
    i_orla_host_model.cmd_write_enable_cmd();
    i_orla_host_model.cmd_prog(base, d2, 1);
    i_orla_host_model.cmd_read(base, sd); check(sd, {prog_result(d1, d2, 8'h00), 8'hFF});
    i_orla_host_model.cmd_write_enable_cmd();
    i_orla_host_model.cmd_prog(base + 24'h1, 8'h00, 0);
    i_orla_host_model.cmd_prog(base + 24'h1, 8'h00, 2);
    i_orla_host_model.cmd_prog(24'h00_0150, 8'h00, 1);
    apb(1'b0, `ORLA_REG_EVENT, 32'h0); check(rd, 32'h0000_0003);
    apb(1'b1, `ORLA_REG_EVENT, 32'h0000_0003);
    apb(1'b0, `ORLA_REG_EVENT, 32'h0); check(rd, 32'h0000_0000);
    emb <= 1'b1;
    i_orla_host_model.cmd_prog(base + 24'h1, 8'h00, 1);
    emb <= 1'b0;
    apb(1'b0, `ORLA_REG_EVENT, 32'h0); check(rd, 32'h0000_0001);
    apb(1'b1, `ORLA_REG_EVENT, 32'h0000_0001);
    i_orla_host_model.set_accel(1'b1);
    apb(1'b0, `ORLA_REG_STATUS, 32'h0); check(rd, 32'h0000_0009);
    i_orla_host_model.cmd_prog(base + 24'h1, 8'h00, 1);
    i_orla_host_model.set_accel(1'b0);
    apb(1'b1, `ORLA_REG_CTRL, 32'h0);
    apb(1'b0, `ORLA_REG_CTRL, 32'h0); check(rd, 32'h0000_0000);
    i_orla_host_model.cmd_prog(base + 24'h1, 8'h00, 1);
    apb(1'b1, `ORLA_REG_CTRL, 32'h0000_0001);
    i_orla_host_model.cmd_read(base, sd); check(sd, {prog_result(d1, d2, 8'h00), 8'hFF});
    check(write_enable_latch, 1'b1);
    quad <= 1'b1;
    i_orla_host_model.set_accel(1'b1);
    i_orla_host_model.cmd_prog(base + 24'h1, 8'h00, 1);
    i_orla_host_model.set_accel(1'b0);
    quad <= 1'b0;
    i_orla_host_model.cmd_read(base, sd); check(sd, {prog_result(d1, d2, 8'h00), 8'h00});
    i_orla_host_model.cmd_write_enable_cmd();
    i_orla_host_model.cmd_prog(24'h00_0100, 8'h00, 1);
    apb(1'b0, `ORLA_REG_ESN_LOCK, 32'h0); check(rd, 32'h0000_00FC);
    i_orla_host_model.cmd_write_enable_cmd();
    i_orla_host_model.cmd_prog(`ORLA_UPPER_SERIAL_REGION_LO, 8'h00, 1);
    i_orla_host_model.cmd_read(`ORLA_UPPER_SERIAL_REGION_LO, sd); check(sd, 16'hFFFF);
    i_orla_host_model.cmd_prog(24'h00_0215, 8'h00, 1);
    apb(1'b0, `ORLA_REG_REGION_LOCK, 32'h0); check(rd, 32'h80FF_FFFF);
    i_orla_host_model.cmd_write_enable_cmd();
    i_orla_host_model.cmd_prog(24'h00_0215, 8'hFF, 1);
    apb(1'b0, `ORLA_REG_REGION_LOCK, 32'h0); check(rd, 32'h80FF_FFFF);
    i_orla_host_model.cmd_write_enable_cmd();
    i_orla_host_model.cmd_prog(24'h00_0396, 8'h00, 1);
    i_orla_host_model.cmd_read(24'h00_0396, sd); check(sd, 16'hFFFF);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({space, write_enable_latch}, 2'b00);
    complete_run();
  end
endmodule : orla_top_tb
`default_nettype wire
